// ===== hdl/nvc_consts.vh
// Constants for the nonvolatile byte store access controller
// Operation
// - 64 bytes, one byte per access
// - Address six bits, upper two read zero
// - Data register eight bits, reset zero
// - Control register at 40H in sector 1
// - Bit 3 program permit, reset zero
// - Bit 2 starts program, self-clears
// - Program trigger ignored without prior permit
// - Bit 1 fetch permit, reset zero
// - Bit 0 starts fetch, self-clears
// - Fetch trigger ignored without prior permit
// - Data holds fetched byte until next op
// - Program time from asynchronous internal timer; code also ends it after PROG_CYC clocks, whichever comes first
// - Power-on clears permit and pointer high bytes
// - Program end sets done and multi flags
// - Irq needs own, multi and global enables
// - Service clears multi flag only
`ifndef NVC_CONSTS_VH
`define NVC_CONSTS_VH
`define NVC_DEPTH        64
`define NVC_AW           6
`define NVC_SEC0         1'b0
`define NVC_SEC1         1'b1
`define NVC_OFS_ADDR     8'h00
`define NVC_OFS_DATA     8'h01
`define NVC_OFS_CTRL     8'h40
`define NVC_SEC_CTRL     1'b1
`define NVC_BIT_PPERMIT  3
`define NVC_BIT_PTRIG    2
`define NVC_BIT_FPERMIT  1
`define NVC_BIT_FTRIG    0
`define NVC_PROG_NS      4000000
`define NVC_CLK_NS       20
`define NVC_PROG_CYC     (`NVC_PROG_NS / `NVC_CLK_NS)
`define NVC_FETCH_CYC    2
`define NVC_RST_BYTE     8'h00
`endif

// ===== hdl/nvc_ctrl.v
// Nonvolatile byte store access controller with internal cell array
`timescale 1ns/1ns
`include "nvc_consts.vh"
module nvc_ctrl #(
	parameter PROG_CYC  = `NVC_PROG_CYC,   // Program cycle length in clocks
	parameter FETCH_CYC = `NVC_FETCH_CYC   // Fetch cycle length in clocks
) (
	input  wire       mclk_i,            // System clock
	input  wire       rst_i,             // Async reset, active high
	input  wire       sec_i,             // Sector select of access
	input  wire [7:0] addr_i,            // Register offset within sector
	input  wire       wr_i,              // Register write strobe
	input  wire [7:0] wdata_i,           // Write data
	output wire [7:0] rdata_o,           // Read data, registered: valid one clock after the select
	input  wire       timer_done_i,      // Async program timer done pulse
	input  wire       nvm_done_irq_enable_i, // Own enable
	input  wire       multi_irq_enable_i,    // Multi-function enable
	input  wire       global_irq_enable_i,   // Global enable
	input  wire       irq_ack_i,         // Interrupt service strobe
	input  wire       done_flag_clr_i,   // Software clear of done flag
	output reg        nvm_done_flag_o,   // Done request flag
	output reg        multi_flag_o,      // Multi-function request flag
	output wire       irq_o,             // Interrupt request to core
	output wire       busy_o             // Cycle in progress
);
	// Cell array, register file and cycle sequencer share one clock;
	// only the program timer done pulse arrives from outside it.
	// Software must not stop the clock while busy_o is high.
	localparam ST_IDLE  = 3'b001;
	localparam ST_FETCH = 3'b010;
	localparam ST_PROG  = 3'b100;
	localparam SEL_NONE = 2'h0;
	localparam SEL_ADDR = 2'h1;
	localparam SEL_DATA = 2'h2;
	localparam SEL_CTRL = 2'h3;

	reg [7:0]            mem_reg [0:`NVC_DEPTH-1];
	reg [`NVC_AW-1:0]    addr_reg;
	reg [7:0]            data_reg;
	reg                  pperm_reg;
	reg                  fperm_reg;
	reg [2:0]            state_reg;
	reg [31:0]           cnt_reg;
	reg [`NVC_AW-1:0]    cap_addr_reg;
	reg [7:0]            cap_data_reg;
	reg                  tsync1_reg;
	reg                  tsync2_reg;
	reg                  tsync3_reg;
	integer              i;
	integer              j;
	reg [`NVC_DEPTH-1:0] row_sel;
	reg [7:0]            rdata_reg;
	reg [7:0]            rdata_next;
	reg [`NVC_AW-1:0]    addr_next;
	reg [7:0]            data_next;
	reg                  pperm_next;
	reg                  fperm_next;
	reg [2:0]            state_next;
	reg [31:0]           cnt_next;
	reg [`NVC_AW-1:0]    cap_addr_next;
	reg [7:0]            cap_data_next;
	reg                  done_flag_next;
	reg                  multi_flag_next;

	function hit;
		input       sec;
		input [7:0] ofs;
		input       fsec;
		input [7:0] fofs;
		begin
			hit = (sec == fsec) && (ofs == fofs);
		end
	endfunction

	// Which register a select names; shared by the write and read paths
	function [1:0] reg_sel;
		input       sec;
		input [7:0] ofs;
		begin
			if (hit(sec, ofs, `NVC_SEC0, `NVC_OFS_ADDR))
				reg_sel = SEL_ADDR;
			else if (hit(sec, ofs, `NVC_SEC0, `NVC_OFS_DATA))
				reg_sel = SEL_DATA;
			else if (hit(sec, ofs, `NVC_SEC_CTRL, `NVC_OFS_CTRL))
				reg_sel = SEL_CTRL;
			else
				reg_sel = SEL_NONE;
		end
	endfunction

	// Terminal count of a cycle counter that starts at zero
	function at_last;
		input [31:0] cnt;
		input [31:0] len;
		begin
			at_last = (cnt == len - 32'h1);
		end
	endfunction

	// Control byte: upper four bits unimplemented and read zero
	function [7:0] ctrl_pack;
		input pperm;
		input ptrig;
		input fperm;
		input ftrig;
		begin
			ctrl_pack = {4'h0, pperm, ptrig, fperm, ftrig};
		end
	endfunction

	wire [1:0] sel = reg_sel(sec_i, addr_i);
	wire wr_addr = wr_i && (sel == SEL_ADDR);
	wire wr_data = wr_i && (sel == SEL_DATA);
	wire wr_ctrl = wr_i && (sel == SEL_CTRL);
	wire idle    = state_reg == ST_IDLE;
	// Trigger counts only if its permit was set before this write and only
	// from idle; both at once is refused in favour of programming
	reg go_prog;
	reg go_fetch;
	always @* begin
		go_prog  = 1'b0;
		go_fetch = 1'b0;
		if (wr_ctrl && idle) begin
			if (wdata_i[`NVC_BIT_PTRIG] && pperm_reg)
				go_prog = 1'b1;
			else if (wdata_i[`NVC_BIT_FTRIG] && fperm_reg)
				go_fetch = 1'b1;
		end
	end
	wire tdone    = tsync2_reg && !tsync3_reg;
	wire prog_end = (state_reg == ST_PROG) &&
		(at_last(cnt_reg, PROG_CYC) || tdone);
	wire fetch_end = (state_reg == ST_FETCH) && at_last(cnt_reg, FETCH_CYC);

	wire [7:0] ctrl_val = ctrl_pack(pperm_reg, state_reg == ST_PROG,
		fperm_reg, state_reg == ST_FETCH);

	assign rdata_o = rdata_reg;
	assign irq_o  = multi_flag_o && nvm_done_irq_enable_i && multi_irq_enable_i
		&& global_irq_enable_i;
	assign busy_o = !idle;

	// Read port is a flip-flop: the byte appears one clock after the select
	always @* begin
		case (sel)
			SEL_ADDR: rdata_next = {2'b00, addr_reg};
			SEL_DATA: rdata_next = data_reg;
			SEL_CTRL: rdata_next = ctrl_val;
			default:  rdata_next = 8'h00;
		endcase
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	// Timer pulse is from another clock domain, so synchronise first
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tsync1_reg <= 1'b0;
			tsync2_reg <= 1'b0;
		end else begin
			tsync1_reg <= timer_done_i;
			tsync2_reg <= tsync1_reg;
		end
	end

	// Edge detector idles low like the pin, so no false end after reset
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			tsync3_reg <= 1'b0;
		else
			tsync3_reg <= tsync2_reg;
	end

	// Software side registers: address and the two permit bits
	always @* begin
		addr_next  = addr_reg;
		pperm_next = pperm_reg;
		fperm_next = fperm_reg;
		// Address may move mid-cycle; the cycle works on its captured copy
		if (wr_addr)
			addr_next = wdata_i[`NVC_AW-1:0];
		// Permit bits follow every control write, trigger writes too
		if (wr_ctrl) begin
			pperm_next = wdata_i[`NVC_BIT_PPERMIT];
			fperm_next = wdata_i[`NVC_BIT_FPERMIT];
		end
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_reg  <= {`NVC_AW{1'b0}};
			pperm_reg <= 1'b0;
			fperm_reg <= 1'b0;
		end else begin
			addr_reg  <= addr_next;
			pperm_reg <= pperm_next;
			fperm_reg <= fperm_next;
		end
	end

	// Cycle sequencer; data register lives here as fetch results land in it
	always @* begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		cap_addr_next = cap_addr_reg;
		cap_data_next = cap_data_reg;
		data_next     = data_reg;
		// Data writes during a cycle are dropped so a fetch result is not lost
		if (wr_data && idle)
			data_next = wdata_i;
		case (state_reg)
			ST_IDLE: begin
				// Counter restarts at zero for every cycle
				cnt_next = 32'h0;
				if (go_prog) begin
					cap_addr_next = addr_reg;
					cap_data_next = data_reg;
					state_next    = ST_PROG;
				end else if (go_fetch) begin
					cap_addr_next = addr_reg;
					state_next    = ST_FETCH;
				end
			end
			ST_PROG: begin
				cnt_next = cnt_reg + 32'h1;
				if (prog_end)
					state_next = ST_IDLE;
			end
			ST_FETCH: begin
				cnt_next = cnt_reg + 32'h1;
				if (fetch_end) begin
					data_next  = mem_reg[cap_addr_reg];
					state_next = ST_IDLE;
				end
			end
			default: begin
				cnt_next   = 32'h0;
				state_next = ST_IDLE;
			end
		endcase
	end

	// Captured copies reset too, so a stray end never writes garbage
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg    <= ST_IDLE;
			cnt_reg      <= 32'h0;
			cap_addr_reg <= {`NVC_AW{1'b0}};
			cap_data_reg <= `NVC_RST_BYTE;
			data_reg     <= `NVC_RST_BYTE;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			cap_addr_reg <= cap_addr_next;
			cap_data_reg <= cap_data_next;
			data_reg     <= data_next;
		end
	end

	// One-hot row select from the captured address; one byte per access
	always @* begin
		for (j = 0; j < `NVC_DEPTH; j = j + 1)
			row_sel[j] = prog_end && (cap_addr_reg == j[`NVC_AW-1:0]);
	end

	// Cell array: no reset, contents are nonvolatile
	always @(posedge mclk_i) begin
		for (i = 0; i < `NVC_DEPTH; i = i + 1)
			if (row_sel[i])
				mem_reg[i] <= cap_data_reg;
	end

	// Set wins over clear on both flags, so an end is never lost
	always @* begin
		done_flag_next  = nvm_done_flag_o;
		multi_flag_next = multi_flag_o;
		if (prog_end) begin
			done_flag_next  = 1'b1;
			multi_flag_next = 1'b1;
		end else begin
			if (done_flag_clr_i)
				done_flag_next  = 1'b0;
			if (irq_ack_i)
				multi_flag_next = 1'b0;
		end
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			nvm_done_flag_o <= 1'b0;
			multi_flag_o    <= 1'b0;
		end else begin
			nvm_done_flag_o <= done_flag_next;
			multi_flag_o    <= multi_flag_next;
		end
	end
endmodule

// ===== tb/nvc_timer.sv
// Model of the asynchronous program timer beside the cell array
`timescale 1ns/1ns
module nvc_timer #(
	parameter DLY = 8 // Clocks from program start to timer done
) (
	input  wire mclk_i, // System clock
	input  wire busy_i, // Cycle running
	output reg  done_o  // Timer done level
);
	integer n = 0;
	initial done_o = 1'b0;
	// Short fetches never reach DLY, so only program cycles see done
	always @(posedge mclk_i) begin
		n <= busy_i ? n + 1 : 0;
		done_o <= busy_i && n >= DLY;
	end
endmodule

// ===== tb/nvc_ctrl_assertions.sv
// Port assertions for the nonvolatile store controller
`timescale 1ns/1ns
module nvc_ctrl_chk (
	input wire logic mclk_i, rst_i, wr_i, irq_ack_i, done_flag_clr_i, busy_o,
	input wire logic nvm_done_flag_o, multi_flag_o, irq_o, nvm_done_irq_enable_i,
	input wire logic multi_irq_enable_i, global_irq_enable_i
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	chk_irq_gate: assert property (
		irq_o == (multi_flag_o && nvm_done_irq_enable_i && multi_irq_enable_i
		&& global_irq_enable_i)) else $error("irq gating wrong");
	chk_no_self_start: assert property (
		!busy_o && !wr_i |=> !busy_o) else $error("cycle without trigger write");
	chk_flags_pair: assert property (
		$rose(multi_flag_o) |-> nvm_done_flag_o) else $error("flags not set together");
	chk_ack_clear: assert property (
		irq_ack_i && !busy_o |=> !multi_flag_o) else $error("service left multi flag");
	chk_done_kept: assert property (
		nvm_done_flag_o && !done_flag_clr_i |=> nvm_done_flag_o) else $error("done flag lost");
	chk_clr_done: assert property (
		done_flag_clr_i && !busy_o |=> !nvm_done_flag_o) else $error("done flag not cleared");
	chk_done_at_end: assert property (
		$rose(nvm_done_flag_o) |-> $past(busy_o)) else $error("done flag without program");
endmodule
bind nvc_ctrl nvc_ctrl_chk chk (.*);

// ===== tb/test_nvc_ctrl.sv
// Register level bench for the nonvolatile store controller
`timescale 1ns/1ns
module test_nvc_ctrl;
	reg        mclk_i = 0, rst_i = 1, sec = 0, wr = 0, en = 0, ack = 0, clr = 0;
	reg  [7:0] adr = 0, wd = 0;
	wire [7:0] rd;
	wire       busy, dflag, mflag, irq, tdone;
	integer    num_errors = 0, tests_run = 0, i;
	always #10 mclk_i = ~mclk_i;
	nvc_ctrl #(.PROG_CYC(20)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .sec_i(sec), .addr_i(adr),
		.wr_i(wr), .wdata_i(wd), .rdata_o(rd), .timer_done_i(tdone),
		.nvm_done_irq_enable_i(en), .multi_irq_enable_i(en), .global_irq_enable_i(en),
		.irq_ack_i(ack), .done_flag_clr_i(clr), .nvm_done_flag_o(dflag),
		.multi_flag_o(mflag), .irq_o(irq), .busy_o(busy));
	nvc_timer tmr (.mclk_i(mclk_i), .busy_i(busy), .done_o(tdone));
	task cmp(input [7:0] g, input [7:0] e); begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	end endtask
	task put(input s, input [7:0] a, input [7:0] d); begin
		@(posedge mclk_i) #1;
		sec = s; adr = a; wd = d; wr = 1;
		@(posedge mclk_i) #1;
		wr = 0;
	end endtask
	task get(input s, input [7:0] a, input [7:0] e); begin
		@(posedge mclk_i) #1;
		sec = s; adr = a;
		@(posedge mclk_i) #1 cmp(rd, e);
	end endtask
	// Bounded wait; a hang shows up in the following compares
	task idle; begin
		for (i = 0; i < 40 && busy !== 1'b0; i = i + 1) @(posedge mclk_i);
		#1;
	end endtask
	task final_report; begin
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end endtask
	initial begin
		#200000 num_errors = num_errors + 1;
		final_report;
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		#1 rst_i = 0;
		get(0, 8'h00, 8'h00);
		get(0, 8'h01, 8'h00);
		get(1, 8'h40, 8'h00);
		put(0, 8'h00, 8'hff); get(0, 8'h00, 8'h3f);
		put(0, 8'h01, 8'ha5); put(1, 8'h40, 8'h04); cmp(busy, 8'h00);
		get(1, 8'h40, 8'h00);
		put(1, 8'h40, 8'h08); put(1, 8'h40, 8'h0c); cmp(busy, 8'h01);
		en = 1; idle; get(1, 8'h40, 8'h08);
		cmp({mflag, dflag, irq}, 8'h07);
		ack = 1; @(posedge mclk_i) #1 ack = 0; cmp({mflag, dflag, irq}, 8'h02);
		clr = 1; @(posedge mclk_i) #1 clr = 0; cmp(dflag, 8'h00);
		put(0, 8'h01, 8'h00); put(1, 8'h40, 8'h02); put(1, 8'h40, 8'h03);
		idle; get(0, 8'h01, 8'ha5);
		get(1, 8'h40, 8'h02);
		put(1, 8'h40, 8'h00); put(1, 8'h40, 8'h01); cmp(busy, 8'h00);
		get(0, 8'h01, 8'ha5);
		final_report;
	end
endmodule
